// ### sra_map.svh
`ifndef SRA_MAP_SVH
`define SRA_MAP_SVH

// ============================================================
// Record layout: byte offsets.
`define SRA_REC_BYTES 74
`define SRA_REC_LEN 16'h004A
`define SRA_HDR_FLAGS 16'h8501
`define SRA_OFF_FLAGS 0
`define SRA_OFF_LEN 2
`define SRA_OFF_SAMPLE 4
`define SRA_OFF_GIN 6
`define SRA_OFF_GOUT 8
`define SRA_OFF_ERR 10
`define SRA_OFF_THREAD 11
`define SRA_OFF_AIN2 12
`define SRA_OFF_AOUT1 14
`define SRA_OFF_AOUT2 16
`define SRA_OFF_AMP 18
`define SRA_OFF_CSEG 22
`define SRA_OFF_CBUF 26
`define SRA_OFF_SSEG 28
`define SRA_OFF_SSTAT 30
`define SRA_OFF_SDIST 32
`define SRA_OFF_SBUF 36
`define SRA_OFF_AXSTAT 38
`define SRA_OFF_SWITCH 40
`define SRA_OFF_STOP 41
`define SRA_OFF_REFPOS 42
`define SRA_OFF_MOTPOS 46
`define SRA_OFF_POSERR 50
`define SRA_OFF_AUXPOS 54
`define SRA_OFF_VEL 58
`define SRA_OFF_TORQ 62
`define SRA_OFF_AIN1 66
`define SRA_OFF_HALL 68
`define SRA_OFF_RSVD 69
`define SRA_OFF_UVAR 70

// ============================================================
// Layout answer and scaling.
`define SRA_LAY_AXES 8'h01
`define SRA_LAY_GEN 8'h12
`define SRA_LAY_PLANE 8'h10
`define SRA_LAY_AXIS 8'h24
`define SRA_LAY_LAST 7'h03
`define SRA_REC_LAST 7'h49
`define SRA_VEL_SHIFT 6
`define SRA_TORQ_MAX 16'h7FFF
`define SRA_TORQ_MIN 16'h8001

// ============================================================
// Register map (byte addresses) and fields.
`define SRA_REG_CTRL 4'h0
`define SRA_REG_PERIOD 4'h4
`define SRA_REG_STATUS 4'h8
`define SRA_REG_UVAR 4'hC
`define SRA_CTRL_QUERY 0
`define SRA_CTRL_PERIODIC 1
`define SRA_CTRL_LAYOUT 2
`define SRA_PERIOD_RST 16'h0001
`define SRA_RESP_OKAY 2'h0
`define SRA_RESP_SLVERR 2'h2

`endif

// ### sra_pkg.sv
`default_nettype none
`include "sra_map.svh"

package sra_pkg;

	typedef enum logic [1:0] {SRA_IDLE, SRA_SEND} sra_state_e;

	// Field order is MSB first so the axis flag struct packs to its status word bit layout.
	typedef struct packed {
		logic move;
		logic abs_or_rel;
		logic abs_only;
		logic edge_find;
		logic homing;
		logic home_ph1;
		logic home_ph2_or_index;
		logic coord;
		logic neg_dir;
		logic contour;
		logic slewing;
		logic stopping;
		logic final_decel;
		logic latch_armed;
		logic home_ph3;
		logic motor_off;
	} sra_axis_flags_s;

	typedef struct packed {
		logic move;
		logic slewing;
		logic stopping;
		logic final_decel;
	} sra_plane_flags_s;

	typedef struct packed {
		logic latch_occurred;
		logic latch_input;
		logic fwd_limit;
		logic rev_limit;
		logic home_input;
		logic stepper;
	} sra_switch_s;

	typedef struct packed {
		logic lockout;
		logic peak_current;
		logic hall_error;
		logic under_volt;
		logic over_temp;
		logic over_volt;
		logic over_current;
	} sra_amp_s;

	typedef struct packed {
		logic [15:0] gen_in;
		logic [15:0] gen_out;
		logic [7:0] error_code;
		logic [5:0] threads;
		logic [15:0] ain1;
		logic [15:0] ain2;
		logic [15:0] aout1;
		logic [15:0] aout2;
		sra_amp_s amp;
		logic [31:0] contour_segs;
		logic [15:0] contour_space;
		logic [15:0] plane_segs;
		sra_plane_flags_s plane;
		logic [31:0] plane_dist;
		logic [15:0] plane_space;
		sra_axis_flags_s axis;
		sra_switch_s switches;
		logic [7:0] stop_code;
		logic [31:0] ref_pos;
		logic [31:0] mot_pos;
		logic [31:0] pos_err;
		logic [31:0] aux_pos;
		logic [31:0] velocity;
		logic [15:0] torque;
		logic [7:0] hall;
	} sra_status_s;

	typedef struct packed {
		sra_state_e st;
		logic [8*`SRA_REC_BYTES-1:0] rec;
		logic [6:0] idx;
		logic [6:0] last_idx;
		logic [7:0] out;
		logic [15:0] sample;
		logic periodic_en;
		logic [15:0] period;
		logic [15:0] period_cnt;
		logic query_pend;
		logic layout_pend;
		logic [31:0] user_var;
		logic [15:0] rec_count;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} sra_regs_s;

endpackage

`default_nettype wire

// ### sra_top.sv
// Functional notes
// - Header flag word: bit 15 one, bits 10, 8, 0 mark blocks present.
// - Header bytes 2 and 3 hold total record length, low byte first.
// - Header content goes out least significant byte first.
// - Bytes 6-7 carry general inputs 1 to 16.
// - Bytes 8-9 carry general outputs 1 to 16.
// - Byte 10 error code; byte 11 thread running bits 0-5, top bits zero.
// - Bytes 22-25 carry the 32-bit contour segment count.
// - Bytes 26-27 carry remaining contour buffer space.
// - Bytes 28-29 carry the plane coordinated segment count.
// - Bytes 30-31 carry the plane coordinated motion status word.
// - Bytes 32-35 carry signed plane distance travelled.
// - Bytes 36-37 carry remaining plane buffer space.
// - Bytes 38-39 carry the axis status word.
// - Byte 40 axis switches, byte 41 axis stop code.
// - Axis positions, error, velocity, torque at fixed 32-bit offsets 42-65.
// - Bytes 70-73 user variable, byte 68 hall status, byte 69 reserved.
// - Axis status word bits 15 to 0 follow the fixed flag order.
// - Plane status uses bits 15, 5, 4, 3; others zero.
// - Switch byte bits 7, 6, 3, 2, 1, 0; bits 5 and 4 zero.
// - Torque clamps to plus or minus 32767, sign extended.
// - Velocity is sixty-four times the raw reported velocity.
// - Layout query returns bytes 1, 18, 16, 36.
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "sra_map.svh"

module sra_top import sra_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire sra_status_s status_in,
	input wire logic sample_tick,
	output logic [7:0] rec_data,
	output logic rec_valid,
	output logic rec_last,
	input wire logic rec_ready
);

	// ============================================================
	// Helpers.

	function automatic logic [31:0] strb_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic is_reg(input logic [31:0] a);
		return (a[31:4] == 28'h0000000) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic [31:0] torque_ext(input logic [15:0] t);
		logic [15:0] c;
		c = (t == 16'h8000) ? `SRA_TORQ_MIN : t;
		return {{16{c[15]}}, c};
	endfunction

	// Little-endian placement falls out of putting each value at
	// bit 8*offset: byte n of the vector is the n-th byte sent.
	function automatic logic [8*`SRA_REC_BYTES-1:0] build_rec(
		input sra_status_s s, input logic [15:0] smp, input logic [31:0] uv);
		logic [8*`SRA_REC_BYTES-1:0] r;
		r = '0;
		r[8*`SRA_OFF_FLAGS +: 16] = `SRA_HDR_FLAGS;
		r[8*`SRA_OFF_LEN +: 16] = `SRA_REC_LEN;
		r[8*`SRA_OFF_SAMPLE +: 16] = smp;
		r[8*`SRA_OFF_GIN +: 16] = s.gen_in;
		r[8*`SRA_OFF_GOUT +: 16] = s.gen_out;
		r[8*`SRA_OFF_ERR +: 8] = s.error_code;
		r[8*`SRA_OFF_THREAD +: 8] = {2'h0, s.threads};
		r[8*`SRA_OFF_AIN2 +: 16] = s.ain2;
		r[8*`SRA_OFF_AOUT1 +: 16] = s.aout1;
		r[8*`SRA_OFF_AOUT2 +: 16] = s.aout2;
		r[8*`SRA_OFF_AMP +: 32] = {7'h00, s.amp.lockout, 7'h00, s.amp.peak_current,
			7'h00, s.amp.hall_error, 4'h0, s.amp.under_volt, s.amp.over_temp,
			s.amp.over_volt, s.amp.over_current};
		r[8*`SRA_OFF_CSEG +: 32] = s.contour_segs;
		r[8*`SRA_OFF_CBUF +: 16] = s.contour_space;
		r[8*`SRA_OFF_SSEG +: 16] = s.plane_segs;
		r[8*`SRA_OFF_SSTAT +: 16] = {s.plane.move, 9'h000, s.plane.slewing,
			s.plane.stopping, s.plane.final_decel, 3'h0};
		r[8*`SRA_OFF_SDIST +: 32] = s.plane_dist;
		r[8*`SRA_OFF_SBUF +: 16] = s.plane_space;
		r[8*`SRA_OFF_AXSTAT +: 16] = s.axis;
		r[8*`SRA_OFF_SWITCH +: 8] = {s.switches.latch_occurred,
			s.switches.latch_input, 2'h0, s.switches.fwd_limit,
			s.switches.rev_limit, s.switches.home_input,
			s.switches.stepper};
		r[8*`SRA_OFF_STOP +: 8] = s.stop_code;
		r[8*`SRA_OFF_REFPOS +: 32] = s.ref_pos;
		r[8*`SRA_OFF_MOTPOS +: 32] = s.mot_pos;
		r[8*`SRA_OFF_POSERR +: 32] = s.pos_err;
		r[8*`SRA_OFF_AUXPOS +: 32] = s.aux_pos;
		r[8*`SRA_OFF_VEL +: 32] = s.velocity << `SRA_VEL_SHIFT;
		r[8*`SRA_OFF_TORQ +: 32] = torque_ext(s.torque);
		r[8*`SRA_OFF_AIN1 +: 16] = s.ain1;
		r[8*`SRA_OFF_HALL +: 8] = s.hall;
		r[8*`SRA_OFF_RSVD +: 8] = 8'h00;
		r[8*`SRA_OFF_UVAR +: 32] = uv;
		return r;
	endfunction

	// ============================================================
	// State.

	sra_regs_s r_q;
	sra_regs_s r_d;
	logic wr_go;
	logic rd_go;
	logic beat;
	logic period_hit;
	logic [31:0] period_wr;
	logic ctrl_wr;
	logic query_set;
	logic layout_set;

	// A request written in the cycle that consumes a pending one must survive.
	assign ctrl_wr = wr_go && is_reg(s_axi_awaddr) && (s_axi_awaddr[3:0] == `SRA_REG_CTRL)
		&& s_axi_wstrb[0];
	assign query_set = ctrl_wr && s_axi_wdata[`SRA_CTRL_QUERY];
	assign layout_set = ctrl_wr && s_axi_wdata[`SRA_CTRL_LAYOUT];
	assign period_wr = strb_merge({16'h0000, r_q.period}, s_axi_wdata, s_axi_wstrb);

	assign wr_go = s_axi_awvalid && s_axi_wvalid && !r_q.bvalid;
	assign rd_go = s_axi_arvalid && !r_q.rvalid;
	assign beat = (r_q.st == SRA_SEND) && rec_ready;
	assign period_hit = sample_tick && r_q.periodic_en && (r_q.period_cnt + 16'h0001 >= r_q.period);

	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_bvalid = r_q.bvalid;
	assign s_axi_bresp = r_q.bresp;
	assign s_axi_arready = rd_go;
	assign s_axi_rvalid = r_q.rvalid;
	assign s_axi_rresp = r_q.rresp;
	assign s_axi_rdata = r_q.rdata;
	assign rec_valid = (r_q.st == SRA_SEND);
	assign rec_data = r_q.out;
	assign rec_last = rec_valid && (r_q.idx == r_q.last_idx);

	// ============================================================
	// Next state.

	always_comb begin
		r_d = r_q;

		// Sample counter wraps freely; the period counter restarts on each hit.
		if (sample_tick) begin
			r_d.sample = r_q.sample + 16'h0001;
			r_d.period_cnt = period_hit ? 16'h0000 : r_q.period_cnt + 16'h0001;
		end
		if (!r_q.periodic_en) begin
			r_d.period_cnt = 16'h0000;
		end

		// Register writes.
		if (r_q.bvalid && s_axi_bready) begin
			r_d.bvalid = 1'b0;
		end
		if (wr_go) begin
			r_d.bvalid = 1'b1;
			r_d.bresp = is_reg(s_axi_awaddr) ? `SRA_RESP_OKAY : `SRA_RESP_SLVERR;
			if (is_reg(s_axi_awaddr)) begin
				case (s_axi_awaddr[3:0])
					`SRA_REG_CTRL: begin
						if (s_axi_wstrb[0]) begin
							r_d.periodic_en = s_axi_wdata[`SRA_CTRL_PERIODIC];
							if (s_axi_wdata[`SRA_CTRL_QUERY]) begin
								r_d.query_pend = 1'b1;
							end
							if (s_axi_wdata[`SRA_CTRL_LAYOUT]) begin
								r_d.layout_pend = 1'b1;
							end
						end
					end
					`SRA_REG_PERIOD: begin
						r_d.period = period_wr[15:0];
					end
					`SRA_REG_UVAR: begin
						r_d.user_var = strb_merge(r_q.user_var, s_axi_wdata, s_axi_wstrb);
					end
					default: begin
						r_d.bresp = `SRA_RESP_OKAY;
					end
				endcase
			end
		end

		// Periodic delivery requests a record; a request is held while busy.
		if (period_hit) begin
			r_d.query_pend = 1'b1;
		end

		// Register reads.
		if (r_q.rvalid && s_axi_rready) begin
			r_d.rvalid = 1'b0;
		end
		if (rd_go) begin
			r_d.rvalid = 1'b1;
			r_d.rresp = is_reg(s_axi_araddr) ? `SRA_RESP_OKAY : `SRA_RESP_SLVERR;
			r_d.rdata = 32'h00000000;
			if (is_reg(s_axi_araddr)) begin
				case (s_axi_araddr[3:0])
					`SRA_REG_CTRL: r_d.rdata = {30'h00000000, r_q.periodic_en, 1'b0};
					`SRA_REG_PERIOD: r_d.rdata = {16'h0000, r_q.period};
					`SRA_REG_STATUS: r_d.rdata = {r_q.rec_count, 13'h0000,
						r_q.layout_pend, r_q.query_pend, (r_q.st == SRA_SEND)};
					`SRA_REG_UVAR: r_d.rdata = r_q.user_var;
					default: r_d.rdata = 32'h00000000;
				endcase
			end
		end

		// Byte streamer. Layout answers take priority over records.
		case (r_q.st)
			SRA_IDLE: begin
				if (r_q.layout_pend) begin
					r_d.layout_pend = layout_set;
					r_d.rec = '0;
					r_d.rec[31:0] = {`SRA_LAY_AXIS, `SRA_LAY_PLANE,
						`SRA_LAY_GEN, `SRA_LAY_AXES};
					r_d.out = `SRA_LAY_AXES;
					r_d.idx = 7'h00;
					r_d.last_idx = `SRA_LAY_LAST;
					r_d.st = SRA_SEND;
				end else if (r_q.query_pend) begin
					r_d.query_pend = period_hit || query_set;
					r_d.rec = build_rec(status_in, r_q.sample, r_q.user_var);
					r_d.out = 8'(`SRA_HDR_FLAGS);
					r_d.idx = 7'h00;
					r_d.last_idx = `SRA_REC_LAST;
					r_d.st = SRA_SEND;
				end
			end
			SRA_SEND: begin
				if (beat) begin
					if (r_q.idx == r_q.last_idx) begin
						r_d.st = SRA_IDLE;
						if (r_q.last_idx == `SRA_REC_LAST) begin
							r_d.rec_count = r_q.rec_count + 16'h0001;
						end
					end else begin
						r_d.idx = r_q.idx + 7'h01;
						r_d.out = r_q.rec[8*(r_q.idx + 7'h01) +: 8];
					end
				end
			end
			default: begin
				r_d.st = SRA_IDLE;
			end
		endcase
	end

	// ============================================================
	// Registers.

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			r_q <= '0;
			r_q.st <= SRA_IDLE;
			r_q.period <= `SRA_PERIOD_RST;
		end else begin
			r_q <= r_d;
		end
	end

endmodule // sra_top

`default_nettype wire

// ### sra_top_props.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Record stream and write response checks.
module sra_top_props (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic [7:0] rec_data,
	input wire logic rec_valid,
	input wire logic rec_last,
	input wire logic rec_ready
);
	logic [6:0] idx_q;
	logic rec_q;
	logic take;
	assign take = rec_valid && rec_ready;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// The second byte tells a full record from a layout answer.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			idx_q <= 7'h00;
			rec_q <= 1'b0;
		end else if (take) begin
			idx_q <= rec_last ? 7'h00 : idx_q + 7'h01;
			if (idx_q == 7'h01) rec_q <= (rec_data == 8'h85);
		end
	end
	property p_head0; rec_valid && idx_q == 7'h00 |-> rec_data == 8'h01; endproperty
	a_head0: assert property (p_head0) else $error("bad first byte");
	property p_head1; rec_valid && idx_q == 7'h01 |-> rec_data inside {8'h85, 8'h12}; endproperty
	a_head1: assert property (p_head1) else $error("bad second byte");
	property p_len;
		rec_valid && rec_q && idx_q inside {7'h02, 7'h03}
			|-> rec_data == ((idx_q == 7'h02) ? 8'h4A : 8'h00);
	endproperty
	a_len: assert property (p_len) else $error("bad length byte");
	property p_last; rec_valid |-> rec_last == (idx_q == (rec_q ? 7'h49 : 7'h03)); endproperty
	a_last: assert property (p_last) else $error("bad end of record");
	property p_thread; rec_valid && rec_q && idx_q == 7'h0B |-> rec_data[7:6] == 2'h0; endproperty
	a_thread: assert property (p_thread) else $error("thread top bits set");
	property p_amp;
		rec_valid && rec_q && idx_q inside {[7'h12:7'h15]}
			|-> rec_data[7:4] == 4'h0 && (idx_q == 7'h12 || rec_data[3:1] == 3'h0);
	endproperty
	a_amp: assert property (p_amp) else $error("amplifier spare bit set");
	property p_plane;
		rec_valid && rec_q && idx_q inside {7'h1E, 7'h1F}
			|-> (rec_data & ((idx_q == 7'h1E) ? 8'hC7 : 8'h7F)) == 8'h00;
	endproperty
	a_plane: assert property (p_plane) else $error("plane spare bit set");
	property p_switch; rec_valid && rec_q && idx_q == 7'h28 |-> rec_data[5:4] == 2'h0; endproperty
	a_switch: assert property (p_switch) else $error("switch spare bit set");
	property p_rsvd; rec_valid && rec_q && idx_q == 7'h45 |-> rec_data == 8'h00; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved byte set");
	property p_wresp;
		s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid
			&& s_axi_bresp == ((|$past(s_axi_awaddr[31:4]) || |$past(s_axi_awaddr[1:0])) ? 2'h2 : 2'h0);
	endproperty
	a_wresp: assert property (p_wresp) else $error("bad write response");
	c_rec: cover property (take && rec_last && rec_q);
	c_lay: cover property (take && rec_last && !rec_q);
	c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // sra_top_props

bind sra_top sra_top_props u_props (.sys_clk(sys_clk), .rst_n(rst_n),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.rec_data(rec_data), .rec_valid(rec_valid), .rec_last(rec_last), .rec_ready(rec_ready));
`default_nettype wire

// ### sra_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Host end of the record stream; in slow mode it stalls at random.
module sra_host_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic slow,
	output logic rec_ready
);
	integer seed = 58;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rec_ready <= 1'b0;
		end else begin
			rec_ready <= !slow || $random(seed) & 1;
		end
	end
endmodule // sra_host_model
`default_nettype wire

// ### status_record_assembler_test.sv
`timescale 1ns/10ps
`default_nettype none
module status_record_assembler_test import sra_pkg::*; ();
	logic sys_clk = 1'b0, rst_n = 1'b0, sample_tick = 1'b0, slow = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, rec_valid, rec_last, rec_ready;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, uv;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] rec_data;
	logic [15:0] smp = '0;
	logic [447:0] rnd;
	sra_status_s st = '0, ns;
	integer seed = 58, mismatches = 0, checked = 0, k;
	logic [8:0] exp_s[$];
	logic [33:0] exp_a[$];
	always #20 sys_clk = ~sys_clk;
	sra_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .status_in(st), .sample_tick(sample_tick),
		.rec_data(rec_data), .rec_valid(rec_valid), .rec_last(rec_last), .rec_ready(rec_ready));
	sra_host_model host (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .rec_ready(rec_ready));
	// ============================================================
	// Checking.
	task automatic end_of_test;
		// Results still expected at the end mean the design stalled or dropped output.
		if (exp_s.size() != 0 || exp_a.size() != 0) mismatches++;
		if (mismatches == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic note(input logic [33:0] got, input logic [33:0] e);
		checked++;
		if (got !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, e);
		end
	endtask
	task automatic cmp_axi(input logic [33:0] got);
		note(got, exp_a.size() ? exp_a.pop_front() : 34'bx);
	endtask
	task automatic cmp_rec(input logic [8:0] got);
		note({25'h0, got}, exp_s.size() ? {25'h0, exp_s.pop_front()} : 34'bx);
	endtask
	// Sampled at the falling edge, where a pending handshake is already settled.
	always @(negedge sys_clk) begin
		if ((s_axi_bvalid && s_axi_bready) === 1'b1) cmp_axi({s_axi_bresp, 32'h0});
		if ((s_axi_rvalid && s_axi_rready) === 1'b1) cmp_axi({s_axi_rresp, s_axi_rdata});
		if ((rec_valid && rec_ready) === 1'b1) cmp_rec({rec_last, rec_data});
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		end_of_test;
	end
	// ============================================================
	// Stimulus.
	task automatic wr(input logic [31:0] a, d, input logic [3:0] sb, input logic [1:0] r);
		@(posedge sys_clk);
		exp_a.push_back({r, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= sb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(negedge sys_clk); while (s_axi_awready !== 1'b1);
		@(posedge sys_clk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(negedge sys_clk); while (s_axi_bvalid !== 1'b1);
		@(posedge sys_clk);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [33:0] e);
		@(posedge sys_clk);
		exp_a.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge sys_clk); while (s_axi_arready !== 1'b1);
		@(posedge sys_clk);
		s_axi_arvalid <= 1'b0;
		do @(negedge sys_clk); while (s_axi_rvalid !== 1'b1);
		@(posedge sys_clk);
		s_axi_rready <= 1'b0;
	endtask
	task automatic put(input logic [63:0] v, input int n);
		for (int i = 0; i < n; i++) exp_s.push_back({1'b0, v[8*i+:8]});
	endtask
	task automatic push_rec(input logic [15:0] sn);
		logic [15:0] tq;
		tq = (ns.torque == 16'h8000) ? 16'h8001 : ns.torque;
		put(16'h8501, 2);
		put(16'h004A, 2);
		put(sn, 2);
		put({ns.gen_out, ns.gen_in}, 4);
		put({2'h0, ns.threads, ns.error_code}, 2);
		put({ns.aout2, ns.aout1, ns.ain2}, 6);
		put({7'h0, ns.amp[6], 7'h0, ns.amp[5], 7'h0, ns.amp[4], 4'h0, ns.amp[3:0]}, 4);
		put(ns.contour_segs, 4);
		put({ns.plane_segs, ns.contour_space}, 4);
		put({ns.plane[3], 9'h0, ns.plane[2:0], 3'h0}, 2);
		put(ns.plane_dist, 4);
		put({ns.axis, ns.plane_space}, 4);
		put({ns.stop_code, ns.switches[5:4], 2'h0, ns.switches[3:0]}, 2);
		put(ns.ref_pos, 4);
		put(ns.mot_pos, 4);
		put(ns.pos_err, 4);
		put(ns.aux_pos, 4);
		put({ns.velocity[25:0], 6'h0}, 4);
		put({{16{tq[15]}}, tq}, 4);
		put({8'h00, ns.hall, ns.ain1}, 4);
		put(uv, 3);
		exp_s.push_back({1'b1, uv[31:24]});
	endtask
	task automatic new_status(input logic neg);
		for (int i = 0; i < 14; i++) rnd[32*i+:32] = $random(seed);
		ns = rnd[$bits(sra_status_s)-1:0];
		if (neg) ns.torque = 16'h8000;
		st <= ns;
	endtask
	task automatic drain;
		repeat (3000) if (exp_s.size() != 0) @(posedge sys_clk);
		repeat (6) @(posedge sys_clk);
	endtask
	task automatic tick;
		@(posedge sys_clk);
		sample_tick <= 1'b1;
		@(posedge sys_clk);
		sample_tick <= 1'b0;
		smp++;
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(32'h0, 34'h0);
		rd(32'h4, 34'h1);
		rd(32'h8, 34'h0);
		rd(32'h10, {2'h2, 32'h0});
		wr(32'h2, 32'h1, 4'hF, 2'h2);
		wr(32'h8, 32'h1, 4'hF, 2'h0);
		uv = $random(seed);
		wr(32'hC, uv, 4'hF, 2'h0);
		wr(32'hC, 32'h5A, 4'h1, 2'h0);
		uv[7:0] = 8'h5A;
		rd(32'hC, {2'h0, uv});
		// The last pass asks again while a record is still going out.
		for (k = 0; k < 3; k++) begin
			new_status(k == 0);
			slow <= k[0];
			push_rec(smp);
			if (k == 2) push_rec(smp);
			wr(32'h0, 32'h1, 4'hF, 2'h0);
			if (k == 2) wr(32'h0, 32'h1, 4'hF, 2'h0);
			drain;
		end
		rd(32'h8, {2'h0, 16'h0004, 16'h0});
		new_status(1'b0);
		put(24'h101201, 3);
		exp_s.push_back(9'h124);
		push_rec(smp);
		wr(32'h0, 32'h5, 4'hF, 2'h0);
		drain;
		wr(32'h4, 32'h0, 4'hF, 2'h0);
		rd(32'h4, 34'h0);
		wr(32'h0, 32'h2, 4'hF, 2'h0);
		rd(32'h0, 34'h2);
		for (k = 0; k < 2; k++) begin
			push_rec(smp + 16'h0001);
			tick;
			drain;
		end
		wr(32'h0, 32'h0, 4'hF, 2'h0);
		tick;
		drain;
		end_of_test;
	end
endmodule // status_record_assembler_test
`default_nettype wire
